// file: design/sss_map.svh
`ifndef SSS_MAP_SVH
`define SSS_MAP_SVH
`define SSS_SS_CYCLES 1024
`define SSS_SS_STEPS 64
`define SSS_SS_STEP_CYC 16
`define SSS_A_CTRL 12'h000
`define SSS_A_STATUS 12'h004
`define SSS_A_IRQ_ST 12'h008
`define SSS_A_IRQ_MASK 12'h00c
`define SSS_CTRL_RST 32'h00000000
`define SSS_CTRL_TRACK 0
`define SSS_CTRL_RUN 1
`define SSS_IRQ_W 4
`endif

// file: design/sss_pkg.sv
package sss_pkg;
    typedef enum logic [2:0] {
        SSS_OFF = 3'b000,
        SSS_SOFT = 3'b001,
        SSS_LIN1 = 3'b010,
        SSS_LIN2 = 3'b011,
        SSS_RUN = 3'b100,
        SSS_HOT = 3'b101
    } sss_state_t;
    typedef struct packed {
        logic main_ok;
        logic lin1_ok;
        logic lin2_ok;
        logic lin3_ok;
        logic lin4_ok;
    } sss_hi_t;
    typedef struct packed {
        logic main_en;
        logic lin1_en;
        logic lin2_en;
        logic lin3_en;
        logic lin4_en;
    } sss_en_t;
endpackage

// file: design/sss_top.sv
`timescale 1ns/1ps
`include "sss_map.svh"
module sss_top #(
    parameter int SS_CYCLES = `SSS_SS_CYCLES,
    parameter int SS_STEPS = `SSS_SS_STEPS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic rail_above_lockout,
    input wire logic ref_above_92,
    input wire logic bias_up,
    input wire logic thermal_hot,
    input wire logic thermal_cooled,
    input wire logic rail_short,
    input wire sss_pkg::sss_hi_t above_92,
    input wire sss_pkg::sss_hi_t above_90,
    input wire logic main_feedback_grounded,
    input wire logic limit_select_at_rail,
    input wire logic pwm_high,
    output logic high_side_gate_drive,
    output logic low_side_gate_drive,
    output logic switching_en,
    output sss_pkg::sss_en_t out_en,
    output logic [5:0] ss_level,
    output logic ss_done,
    output logic use_preset_sense,
    output logic default_limit,
    output logic power_good_out_o,
    output logic power_good_out_oe
);
    localparam int STEP_CYC = SS_CYCLES / SS_STEPS;
    localparam int SW = $clog2(SS_CYCLES + 1);

    // three-stage sync; a change counts when stages two and three agree
    logic [12:0] raw, s1, s2, s3, q_r;
    assign raw = {rail_above_lockout, ref_above_92, bias_up, thermal_hot,
        thermal_cooled, rail_short, main_feedback_grounded,
        limit_select_at_rail, pwm_high, 4'h0};
    sss_pkg::sss_hi_t h92_s1, h92_s2, h92_s3, h92;
    sss_pkg::sss_hi_t h90_s1, h90_s2, h90_s3, h90;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= 13'h0;
            s2 <= 13'h0;
            s3 <= 13'h0;
            q_r <= 13'h0;
        end else begin
            s1 <= raw;
            s2 <= s1;
            s3 <= s2;
            q_r <= (s2 & s3) | (q_r & (s2 | s3));
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            h92_s1 <= '0;
            h92_s2 <= '0;
            h92_s3 <= '0;
            h92 <= '0;
            h90_s1 <= '0;
            h90_s2 <= '0;
            h90_s3 <= '0;
            h90 <= '0;
        end else begin
            h92_s1 <= above_92;
            h92_s2 <= h92_s1;
            h92_s3 <= h92_s2;
            h92 <= (h92_s2 & h92_s3) | (h92 & (h92_s2 | h92_s3));
            h90_s1 <= above_90;
            h90_s2 <= h90_s1;
            h90_s3 <= h90_s2;
            h90 <= (h90_s2 & h90_s3) | (h90 & (h90_s2 | h90_s3));
        end
    end
    logic rail_ok, ref_ok, bias_ok, hot, cooled, rshort, pwm_q;
    assign rail_ok = q_r[12];
    assign ref_ok = q_r[11];
    assign bias_ok = q_r[10];
    assign hot = q_r[9];
    assign cooled = q_r[8];
    assign rshort = q_r[7];
    assign pwm_q = q_r[4];

    // registers
    logic [1:0] ctrl_r;
    logic [`SSS_IRQ_W-1:0] ist_r, imask_r, ev;
    logic track;
    assign track = ctrl_r[`SSS_CTRL_TRACK];
    logic wr, rd;
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    assign pready = 1'b1;
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == `SSS_A_CTRL) || (a == `SSS_A_STATUS) ||
            (a == `SSS_A_IRQ_ST) || (a == `SSS_A_IRQ_MASK);
    endfunction
    assign pslverr = psel && penable && !mapped(paddr);

    // thermal latch: trips hot, waits for 15-degree cool indication
    logic therm_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            therm_r <= 1'b0;
        end else if (rshort) begin
            therm_r <= 1'b0;
        end else if (hot) begin
            therm_r <= 1'b1;
        end else if (cooled) begin
            therm_r <= 1'b0;
        end
    end

    logic enable;
    assign enable = rail_ok && ref_ok && bias_ok && !therm_r;
    logic done_r;
    assign ss_done = done_r;

    sss_pkg::sss_state_t st_r, st_nxt;
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            sss_pkg::SSS_OFF: begin
                if (enable) st_nxt = sss_pkg::SSS_SOFT;
            end
            sss_pkg::SSS_SOFT: begin
                if (track) st_nxt = sss_pkg::SSS_RUN;
                else if (done_r && h92.main_ok) st_nxt = sss_pkg::SSS_LIN1;
            end
            sss_pkg::SSS_LIN1: begin
                if (h92.lin1_ok) st_nxt = sss_pkg::SSS_LIN2;
            end
            sss_pkg::SSS_LIN2: st_nxt = sss_pkg::SSS_RUN;
            sss_pkg::SSS_RUN: st_nxt = sss_pkg::SSS_RUN;
            sss_pkg::SSS_HOT: begin
                if (!therm_r) st_nxt = sss_pkg::SSS_OFF;
            end
            default: st_nxt = sss_pkg::SSS_OFF;
        endcase
        if (!rail_ok) st_nxt = sss_pkg::SSS_OFF;
        else if (therm_r) st_nxt = sss_pkg::SSS_HOT;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) st_r <= sss_pkg::SSS_OFF;
        else st_r <= st_nxt;
    end

    // soft-start counter; cleared on lockout or thermal event
    logic [SW-1:0] ss_cnt_r;
    logic ss_active;
    assign ss_active = (st_r != sss_pkg::SSS_OFF) &&
        (st_r != sss_pkg::SSS_HOT);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ss_cnt_r <= '0;
            done_r <= 1'b0;
        end else if (!ss_active) begin
            ss_cnt_r <= '0;
            done_r <= 1'b0;
        end else if (ss_cnt_r < SW'(SS_CYCLES)) begin
            ss_cnt_r <= ss_cnt_r + 1'b1;
            if (ss_cnt_r == SW'(SS_CYCLES - 1)) done_r <= 1'b1;
        end
    end
    // one dac step each STEP_CYC cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ss_level <= 6'h00;
        else if (!ss_active) ss_level <= 6'h00;
        else if (ss_cnt_r < SW'(SS_CYCLES))
            ss_level <= 6'(ss_cnt_r / SW'(STEP_CYC));
    end

    // outputs enabled by state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_en <= '0;
            switching_en <= 1'b0;
        end else begin
            switching_en <= ss_active;
            out_en.main_en <= ss_active;
            out_en.lin1_en <= ss_active && (track ||
                st_r == sss_pkg::SSS_LIN1 || st_r == sss_pkg::SSS_LIN2 ||
                st_r == sss_pkg::SSS_RUN);
            out_en.lin2_en <= ss_active && (track ||
                st_r == sss_pkg::SSS_LIN2 ||
                st_r == sss_pkg::SSS_RUN);
            out_en.lin3_en <= ss_active && track;
            out_en.lin4_en <= ss_active && track;
        end
    end

    // gate drives complement each other; both low when stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_side_gate_drive <= 1'b0;
            low_side_gate_drive <= 1'b0;
        end else if (!switching_en || !rail_ok || therm_r) begin
            high_side_gate_drive <= 1'b0;
            low_side_gate_drive <= 1'b0;
        end else begin
            high_side_gate_drive <= pwm_q;
            low_side_gate_drive <= !pwm_q;
        end
    end

    // power-good hysteresis: 92% sets, 90% clears
    logic all92, any_below90, pg_r;
    assign all92 = track ? (&h92) :
        (h92.main_ok && h92.lin1_ok && h92.lin2_ok);
    assign any_below90 = track ? !(&h90) :
        !(h90.main_ok && h90.lin1_ok && h90.lin2_ok);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) pg_r <= 1'b0;
        else if (!ss_active || any_below90) pg_r <= 1'b0;
        else if (all92 && done_r && st_r == sss_pkg::SSS_RUN)
            pg_r <= 1'b1;
    end
    assign power_good_out_o = 1'b0;
    assign power_good_out_oe = !pg_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            use_preset_sense <= 1'b0;
            default_limit <= 1'b0;
        end else begin
            use_preset_sense <= q_r[6];
            default_limit <= q_r[5];
        end
    end

    // interrupts: done, power-good up, power-good lost, thermal trip
    logic pg_d, therm_d, done_d;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pg_d <= 1'b0;
            therm_d <= 1'b0;
            done_d <= 1'b0;
        end else begin
            pg_d <= pg_r;
            therm_d <= therm_r;
            done_d <= done_r;
        end
    end
    assign ev = {therm_r & !therm_d, pg_d & !pg_r, pg_r & !pg_d,
        done_r & !done_d};
    // set beats a same-cycle write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist_r <= '0;
        end else if (wr && paddr == `SSS_A_IRQ_ST) begin
            ist_r <= (ist_r & ~pwdata[`SSS_IRQ_W-1:0]) | ev;
        end else begin
            ist_r <= ist_r | ev;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imask_r <= '0;
            ctrl_r <= 2'(`SSS_CTRL_RST);
        end else if (wr && paddr == `SSS_A_IRQ_MASK) begin
            imask_r <= pwdata[`SSS_IRQ_W-1:0];
        end else if (wr && paddr == `SSS_A_CTRL) begin
            ctrl_r <= pwdata[1:0];
        end
    end
    assign irq = |(ist_r & imask_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `SSS_A_CTRL: prdata <= {30'h0, ctrl_r};
                `SSS_A_STATUS: prdata <= {19'h0, st_r, ss_level, pg_r,
                    done_r, therm_r, enable};
                `SSS_A_IRQ_ST: prdata <= {28'h0, ist_r};
                `SSS_A_IRQ_MASK: prdata <= {28'h0, imask_r};
                default: prdata <= 32'h0;
            endcase
        end
    end

    property p_lockout_gates;
        @(posedge pclk) disable iff (!presetn)
        !rail_ok |=> !high_side_gate_drive && !low_side_gate_drive;
    endproperty
    a_lockout_gates: assert property (p_lockout_gates)
        else $error("gates not low in lockout");
    property p_enable;
        @(posedge pclk) disable iff (!presetn)
        $rose(st_r == sss_pkg::SSS_SOFT) |->
            $past(rail_ok && ref_ok && bias_ok && !therm_r);
    endproperty
    a_enable: assert property (p_enable)
        else $error("start without all enable conditions");
    property p_start;
        @(posedge pclk) disable iff (!presetn)
        st_r == sss_pkg::SSS_SOFT && rail_ok && !therm_r |=> switching_en;
    endproperty
    a_start: assert property (p_start)
        else $error("switching not started");
    property p_ss_len;
        @(posedge pclk) disable iff (!presetn)
        $rose(done_r) |-> ss_cnt_r == SW'(SS_CYCLES);
    endproperty
    a_ss_len: assert property (p_ss_len)
        else $error("soft-start length wrong");
    property p_lin1;
        @(posedge pclk) disable iff (!presetn)
        $rose(out_en.lin1_en) && !track |-> $past(done_r && h92.main_ok);
    endproperty
    a_lin1: assert property (p_lin1)
        else $error("linear one enabled early");
    property p_lin2;
        @(posedge pclk) disable iff (!presetn)
        $rose(out_en.lin2_en) && !track |-> out_en.lin1_en;
    endproperty
    a_lin2: assert property (p_lin2)
        else $error("linear two before linear one");
    property p_pg_low;
        @(posedge pclk) disable iff (!presetn)
        pg_r && any_below90 |=> !pg_r && power_good_out_oe;
    endproperty
    a_pg_low: assert property (p_pg_low)
        else $error("power-good not pulled low");
    property p_pg_rise;
        @(posedge pclk) disable iff (!presetn)
        $rose(pg_r) |-> $past(all92 && done_r);
    endproperty
    a_pg_rise: assert property (p_pg_rise)
        else $error("power-good released early");
    property p_therm;
        @(posedge pclk) disable iff (!presetn)
        therm_r |-> ##2 (!out_en.main_en && ss_cnt_r == '0);
    endproperty
    a_therm: assert property (p_therm)
        else $error("thermal event did not shut down");
    c_done: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(done_r));
    c_pg: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(pg_r));
    c_hot: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(therm_r));
endmodule

// file: testbench/sss_rail_model.sv
`timescale 1ns/1ps
module sss_rail_model #(
    parameter int DLY = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire sss_pkg::sss_en_t out_en,
    input wire logic [4:0] sag,
    output sss_pkg::sss_hi_t above_92,
    output sss_pkg::sss_hi_t above_90
);
    // each rail ramps for DLY cycles once enabled; sag models a short
    int ramp_r [5];
    logic [4:0] hi92;
    logic [4:0] hi90;
    always @(posedge pclk or negedge presetn) begin
        for (int i = 0; i < 5; i++) begin
            if (!presetn || !out_en[i] || sag[i]) begin
                ramp_r[i] <= 0;
            end else if (ramp_r[i] < DLY) begin
                ramp_r[i] <= ramp_r[i] + 1;
            end
        end
    end
    // 90% trips two cycles before 92%, so hysteresis is exercised
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            hi92[i] = ramp_r[i] >= DLY;
            hi90[i] = ramp_r[i] >= DLY - 2;
        end
    end
    assign above_92 = sss_pkg::sss_hi_t'(hi92);
    assign above_90 = sss_pkg::sss_hi_t'(hi90);
endmodule

// file: testbench/sss_top_tb_top.sv
`timescale 1ns/1ps
`include "sss_map.svh"
module sss_top_tb_top;
    localparam int SS = 64;
    localparam int STEPS = 4;
    typedef struct packed {
        logic [3:0] s;
        logic [31:0] v;
    } sss_note_t;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic rail = 1'h0;
    logic ref_ok = 1'h0;
    logic bias = 1'h0;
    logic hot = 1'h0;
    logic cooled = 1'h0;
    logic rshort = 1'h0;
    logic feed_gnd = 1'h0;
    logic lim_rail = 1'h0;
    logic pwm = 1'h0;
    logic [4:0] sag = 5'h0;
    sss_pkg::sss_hi_t a92;
    sss_pkg::sss_hi_t a90;
    logic hs;
    logic ls;
    logic sw_en;
    sss_pkg::sss_en_t out_en;
    logic ss_done;
    logic [5:0] ss_lvl;
    logic preset_s;
    logic dflt_lim;
    logic pg_o;
    logic pg_oe;
    logic [31:0] rd_last = 32'h0;
    logic err_last = 1'h0;
    logic [7:0] lf = 8'h25;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc_cnt = 0;
    sss_note_t exp_q[$];
    event res_ev;
    always #20 pclk = ~pclk;
    sss_top #(.SS_CYCLES(SS), .SS_STEPS(STEPS)) sss_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .rail_above_lockout(rail), .ref_above_92(ref_ok),
        .bias_up(bias), .thermal_hot(hot), .thermal_cooled(cooled),
        .rail_short(rshort), .above_92(a92), .above_90(a90),
        .main_feedback_grounded(feed_gnd), .limit_select_at_rail(lim_rail),
        .pwm_high(pwm), .high_side_gate_drive(hs),
        .low_side_gate_drive(ls), .switching_en(sw_en), .out_en(out_en),
        .ss_level(ss_lvl), .ss_done(ss_done), .use_preset_sense(preset_s),
        .default_limit(dflt_lim), .power_good_out_o(pg_o),
        .power_good_out_oe(pg_oe)
    );
    sss_rail_model sss_rail_model_inst (
        .pclk(pclk), .presetn(presetn), .out_en(out_en), .sag(sag),
        .above_92(a92), .above_90(a90)
    );
    function automatic logic [7:0] lfsr_next(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    // pull-up on the power-good line: released reads high
    function automatic logic [31:0] probe(input logic [3:0] s);
        case (s)
            4'h0: return rd_last;
            4'h1: return 32'(err_last);
            4'h2: return 32'(sw_en);
            4'h3: return 32'({hs, ls});
            4'h4: return 32'(pg_oe ? pg_o : 1'h1);
            4'h5: return 32'(out_en);
            4'h6: return 32'(ss_done);
            4'h7: return 32'(irq);
            4'h8: return 32'(preset_s);
            4'h9: return 32'(dflt_lim);
            4'ha: return 32'(hs ^ ls);
            4'hc: return 32'(ss_lvl);
            default: return 32'(out_en.main_en);
        endcase
    endfunction
    always @(posedge pclk) begin
        lf <= lfsr_next(lf);
        pwm <= lf[0];
        cyc_cnt++;
        if (cyc_cnt == 6000) begin
            error_cnt++;
            test_done();
        end
    end
    always @(res_ev) begin
        sss_note_t nt;
        while (exp_q.size() > 0) begin
            nt = exp_q.pop_front();
            n_compared++;
            if (probe(nt.s) !== nt.v) begin
                error_cnt++;
                $display("[FAIL] t=%0t sel=%0h exp=%h got=%h", $time,
                    nt.s, nt.v, probe(nt.s));
            end
        end
    end
    task automatic test_done();
        $display("compared=%0d errors=%0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // sampled at negedge so registered outputs have settled
    task automatic wf(input logic [3:0] s, input logic [31:0] v,
                      input int max);
        int n;
        n = 0;
        @(negedge pclk);
        while (probe(s) !== v && n < max) begin
            @(negedge pclk);
            n++;
        end
        exp_q.push_back({s, v});
        -> res_ev;
        @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) begin
            @(posedge pclk);
        end
        rd_last = prdata;
        err_last = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        wf(4'h4, 32'h0, 0);
        wf(4'h3, 32'h0, 0);
        apb(1'h0, `SSS_A_CTRL, 32'h0);
        wf(4'h0, `SSS_CTRL_RST, 0);
        apb(1'h0, 12'h010, 32'h0);
        wf(4'h1, 32'h1, 0);
        wf(4'h0, 32'h0, 0);
        rail <= 1'h1;
        ref_ok <= 1'h1;
        repeat (12) @(posedge pclk);
        wf(4'h2, 32'h0, 0);
        bias <= 1'h1;
        wf(4'h2, 32'h1, 12);
        wf(4'ha, 32'h1, 4);
        repeat (SS - 16) @(posedge pclk);
        wf(4'h6, 32'h0, 0);
        wf(4'h6, 32'h1, 24);
        wf(4'h5, 32'h10, 0);
        wf(4'hc, 32'(STEPS - 1), 0);
        wf(4'h4, 32'h0, 0);
        wf(4'h5, 32'h18, 8);
        wf(4'h5, 32'h1c, 16);
        wf(4'h4, 32'h1, 24);
        wf(4'h7, 32'h0, 0);
        apb(1'h0, `SSS_A_IRQ_ST, 32'h0);
        wf(4'h0, 32'h3, 0);
        apb(1'h1, `SSS_A_IRQ_MASK, 32'h2);
        wf(4'h7, 32'h1, 2);
        apb(1'h1, `SSS_A_IRQ_ST, 32'h3);
        wf(4'h7, 32'h0, 2);
        apb(1'h1, `SSS_A_IRQ_MASK, 32'h4);
        sag <= 5'h10;
        wf(4'h4, 32'h0, 8);
        wf(4'h7, 32'h1, 4);
        sag <= 5'h0;
        wf(4'h4, 32'h1, 24);
        apb(1'h1, `SSS_A_IRQ_ST, 32'h4);
        wf(4'h7, 32'h0, 2);
        for (int i = 0; i < 4; i++) begin
            logic fg;
            logic lr;
            fg = lf[1];
            lr = lf[2];
            feed_gnd <= fg;
            lim_rail <= lr;
            wf(4'h8, 32'(fg), 8);
            wf(4'h9, 32'(lr), 8);
        end
        hot <= 1'h1;
        wf(4'h2, 32'h0, 8);
        wf(4'h3, 32'h0, 0);
        wf(4'h5, 32'h0, 4);
        wf(4'h4, 32'h0, 0);
        wf(4'h6, 32'h0, 0);
        hot <= 1'h0;
        repeat (12) @(posedge pclk);
        wf(4'h2, 32'h0, 0);
        cooled <= 1'h1;
        wf(4'h2, 32'h1, 12);
        cooled <= 1'h0;
        rshort <= 1'h1;
        hot <= 1'h1;
        repeat (12) @(posedge pclk);
        wf(4'h2, 32'h1, 0);
        hot <= 1'h0;
        rshort <= 1'h0;
        apb(1'h1, `SSS_A_CTRL, 32'h1);
        rail <= 1'h0;
        wf(4'h2, 32'h0, 8);
        wf(4'h4, 32'h0, 0);
        rail <= 1'h1;
        wf(4'hb, 32'h1, 16);
        wf(4'h5, 32'h1f, 0);
        wf(4'h4, 32'h0, 0);
        wf(4'h6, 32'h1, SS + 8);
        wf(4'h4, 32'h1, 24);
        test_done();
    end
endmodule
